// ===== core/paged_external_data_move_stretch_timing.v
`timescale 1ns/1ns
`include "paged_external_data_move_stretch_timing_defs.vh"
module paged_external_data_move_stretch_timing #(
  parameter SLOW_DIV = `SLOW_DIV_DEFAULT
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire req_valid,
  output wire req_ready,
  input wire req_write,
  input wire [15:0] req_addr,
  input wire [7:0] req_wdata,
  output reg done,
  output reg [7:0] rdata,
  output reg ale,
  output reg rd_n,
  output reg wr_n,
  output reg [7:0] port0_out,
  output reg port0_oe,
  input wire [7:0] port0_in,
  output reg [7:0] port2_out,
  output reg port2_oe,
  input wire [7:0] port2_in
);

  localparam ST_IDLE = 5'b00001;
  localparam ST_ADDR = 5'b00010;
  localparam ST_SETUP = 5'b00100;
  localparam ST_STROBE = 5'b01000;
  localparam ST_HOLD = 5'b10000;

  reg [8:0] ctrl_reg;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [4:0] cnt_reg;
  reg [4:0] cnt_next;
  reg [2:0] stretch_reg;
  reg [1:0] pages_reg;
  reg paged_reg;
  reg miss_reg;
  reg write_reg;
  reg [15:0] addr_reg;
  reg [7:0] wdata_reg;
  reg [7:0] last_page_reg;
  reg page_valid_reg;
  reg [7:0] len_reg;
  reg [7:0] last_len_reg;
  reg last_miss_reg;
  reg [9:0] div_reg;
  wire sys_tick;
  wire start;
  wire miss_now;
  wire mode2;
  wire apb_setup;
  wire apb_write;
  wire hit_ctrl;
  wire hit_status;
  wire [15:0] pin_addr;
  wire pin_mode2;

  // strobe width in system clocks at divide-by-one
  function [4:0] strobe_len;
    input [2:0] code;
    input [1:0] pages;
    reg [4:0] w;
    begin
      w = {code, 2'b00};
      if (pages[1]) begin
        strobe_len = (code == 3'b000) ? 5'h02 : w;
      end else begin
        strobe_len = (code == 3'b000) ? 5'h01 : w - 5'h01;
      end
    end
  endfunction

  // address setup phase length
  function [4:0] setup_len;
    input [2:0] code;
    begin
      if (code == 3'b000) begin
        setup_len = `BASE_PHASE;
      end else if (!code[2]) begin
        setup_len = `BASE_PHASE + `GRP1_SETUP_ADD;
      end else begin
        setup_len = `BASE_PHASE + `GRP2_SETUP_ADD;
      end
    end
  endfunction

  // address and data hold phase length
  function [4:0] hold_len;
    input [2:0] code;
    begin
      if (code == 3'b000) begin
        hold_len = `BASE_PHASE;
      end else if (!code[2]) begin
        hold_len = `BASE_PHASE + `GRP1_HOLD_ADD;
      end else begin
        hold_len = `BASE_PHASE + `GRP2_HOLD_ADD;
      end
    end
  endfunction

  // address latch phase length
  function [4:0] ale_len;
    input [2:0] code;
    begin
      ale_len = code[2] ? `BASE_PHASE + `GRP2_ALE_ADD : `BASE_PHASE;
    end
  endfunction

  // apb decode, zero wait states
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign hit_ctrl = (paddr == `OFS_CTRL);
  assign hit_status = (paddr == `OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_ctrl && !hit_status;

  // system clock enable from the divider setting
  assign sys_tick = (ctrl_reg[`CTRL_CDIV_MSB:`CTRL_CDIV_LSB] == `CDIV_SLOW) ?
    (div_reg == SLOW_DIV[9:0] - 10'h001) : 1'b1;

  // page mode 2 or non-page bus always emits the address phase
  assign mode2 = (pages_reg == `PAGES_MODE2);
  assign miss_now = !ctrl_reg[`CTRL_PAGED_EN] ||
    ({ctrl_reg[`CTRL_PAGE_HI], ctrl_reg[`CTRL_PAGE_LO]} == `PAGES_MODE2) ||
    ({ctrl_reg[`CTRL_PAGE_HI], ctrl_reg[`CTRL_PAGE_LO]} == `PAGES_ONE) ||
    !page_valid_reg || (req_addr[15:8] != last_page_reg);
  assign req_ready = (state_reg == ST_IDLE);
  assign start = ce && req_valid && req_ready;

  // latched copies load on the taking edge, so the pins use the request there
  assign pin_addr = start ? req_addr : addr_reg;
  assign pin_mode2 = start ? (ctrl_reg[`CTRL_PAGED_EN] &&
    ({ctrl_reg[`CTRL_PAGE_HI], ctrl_reg[`CTRL_PAGE_LO]} == `PAGES_MODE2)) :
    (mode2 && paged_reg);

  // divider counter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= 10'h000;
    end else if (ce) begin
      if (sys_tick || ctrl_reg[`CTRL_CDIV_MSB:`CTRL_CDIV_LSB] != `CDIV_SLOW) begin
        div_reg <= 10'h000;
      end else begin
        div_reg <= div_reg + 10'h001;
      end
    end
  end

  // register file writes and read data
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `CTRL_RESET;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (apb_write && hit_ctrl) begin
        ctrl_reg <= pwdata[8:0];
      end
      if (apb_setup) begin
        if (paddr == `OFS_CTRL) begin
          prdata <= {23'h00_0000, ctrl_reg};
        end else if (paddr == `OFS_STATUS) begin
          prdata <= {16'h0000, last_len_reg, 6'h00, last_miss_reg, !req_ready};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // phase sequencer
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_SETUP;
          cnt_next = setup_len(ctrl_reg[2:0]);
          if (miss_now) begin
            state_next = ST_ADDR;
            cnt_next = ale_len(ctrl_reg[2:0]);
          end
        end
      end
      ST_ADDR: begin
        if (sys_tick) begin
          cnt_next = cnt_reg - 5'h01;
          if (cnt_reg == 5'h01) begin
            state_next = ST_SETUP;
            cnt_next = setup_len(stretch_reg);
          end
        end
      end
      ST_SETUP: begin
        if (sys_tick) begin
          cnt_next = cnt_reg - 5'h01;
          if (cnt_reg == 5'h01) begin
            state_next = ST_STROBE;
            cnt_next = strobe_len(stretch_reg, pages_reg);
          end
        end
      end
      ST_STROBE: begin
        if (sys_tick) begin
          cnt_next = cnt_reg - 5'h01;
          if (cnt_reg == 5'h01) begin
            state_next = ST_HOLD;
            cnt_next = hold_len(stretch_reg);
          end
        end
      end
      ST_HOLD: begin
        if (sys_tick) begin
          cnt_next = cnt_reg - 5'h01;
          if (cnt_reg == 5'h01) begin
            state_next = ST_IDLE;
            cnt_next = 5'h00;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next = 5'h00;
      end
    endcase
  end

  // state, latched settings and access bookkeeping
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
      stretch_reg <= 3'b000;
      pages_reg <= 2'b00;
      paged_reg <= 1'b0;
      miss_reg <= 1'b0;
      write_reg <= 1'b0;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      last_page_reg <= 8'h00;
      page_valid_reg <= 1'b0;
      len_reg <= 8'h00;
      last_len_reg <= 8'h00;
      last_miss_reg <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done <= 1'b0;
      if (start) begin
        stretch_reg <= ctrl_reg[`CTRL_STRETCH_MSB:`CTRL_STRETCH_LSB];
        pages_reg <= {ctrl_reg[`CTRL_PAGE_HI], ctrl_reg[`CTRL_PAGE_LO]};
        paged_reg <= ctrl_reg[`CTRL_PAGED_EN];
        miss_reg <= miss_now;
        write_reg <= req_write;
        addr_reg <= req_addr;
        wdata_reg <= req_wdata;
        last_page_reg <= req_addr[15:8];
        page_valid_reg <= ctrl_reg[`CTRL_PAGED_EN] &&
          ({ctrl_reg[`CTRL_PAGE_HI], ctrl_reg[`CTRL_PAGE_LO]} != `PAGES_ONE);
        len_reg <= 8'h00;
      end else if (state_reg != ST_IDLE && sys_tick) begin
        len_reg <= len_reg + 8'h01;
      end
      // sample read data on the last strobe clock
      if (state_reg == ST_STROBE && sys_tick && cnt_reg == 5'h01 && !write_reg) begin
        rdata <= (mode2 && paged_reg) ? port2_in : port0_in;
      end
      if (state_reg == ST_HOLD && sys_tick && cnt_reg == 5'h01) begin
        done <= 1'b1;
        last_len_reg <= len_reg + 8'h01;
        last_miss_reg <= miss_reg;
      end
    end
  end

  // bus pin drive per phase
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      port0_out <= 8'h00;
      port0_oe <= 1'b0;
      port2_out <= 8'h00;
      port2_oe <= 1'b0;
    end else if (ce) begin
      ale <= (state_next == ST_ADDR);
      rd_n <= !(state_next == ST_STROBE && !write_reg);
      wr_n <= !(state_next == ST_STROBE && write_reg);
      if (pin_mode2) begin
        // low byte on port0, high byte shares port2 with data
        port0_out <= pin_addr[7:0];
        port0_oe <= (state_next != ST_IDLE);
        if (state_next == ST_ADDR || state_next == ST_SETUP) begin
          port2_out <= pin_addr[15:8];
          port2_oe <= 1'b1;
        end else begin
          port2_out <= wdata_reg;
          port2_oe <= write_reg && (state_next == ST_STROBE || state_next == ST_HOLD);
        end
      end else begin
        // low byte multiplexed with data on port0
        port2_out <= pin_addr[15:8];
        port2_oe <= (state_next != ST_IDLE);
        if (state_next == ST_ADDR) begin
          port0_out <= pin_addr[7:0];
          port0_oe <= 1'b1;
        end else begin
          port0_out <= wdata_reg;
          port0_oe <= write_reg && (state_next == ST_STROBE || state_next == ST_HOLD);
        end
      end
    end
  end

endmodule

// ===== core/paged_external_data_move_stretch_timing_defs.vh
`ifndef PAGED_EXTERNAL_DATA_MOVE_STRETCH_TIMING_DEFS_VH
`define PAGED_EXTERNAL_DATA_MOVE_STRETCH_TIMING_DEFS_VH

// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004

// control field positions
`define CTRL_STRETCH_LSB 0
`define CTRL_STRETCH_MSB 2
`define CTRL_PAGE_LO 3
`define CTRL_PAGE_HI 4
`define CTRL_PAGED_EN 5
`define CTRL_CDIV_LSB 6
`define CTRL_CDIV_MSB 7
`define CTRL_CMUL 8

// control reset value: no stretch, non-page, divide-by-one
`define CTRL_RESET 9'h080

// clock divide codes
`define CDIV_DIV1 2'b10
`define CDIV_SLOW 2'b11

// page select codes
`define PAGES_ONE 2'b00
`define PAGES_TWO 2'b01
`define PAGES_FOUR 2'b10
`define PAGES_MODE2 2'b11

// slow divide ratio in input clocks, timing counts in system clocks
`define SLOW_DIV_DEFAULT 1024
`define STRETCH_CLKS 5'h04
`define GRP1_SETUP_ADD 5'h01
`define GRP1_HOLD_ADD 5'h01
`define GRP2_SETUP_ADD 5'h08
`define GRP2_HOLD_ADD 5'h04
`define GRP2_ALE_ADD 5'h04
`define BASE_PHASE 5'h01

`endif

// ===== bench/paged_external_data_move_stretch_timing_assertions.sv
`timescale 1ns/1ns
module paged_external_data_move_stretch_timing_assertions (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire req_valid,
  input wire req_ready,
  input wire done,
  input wire ale,
  input wire rd_n,
  input wire wr_n,
  input wire port0_oe,
  input wire port2_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // an access taken on this edge
  sequence take_s;
    req_valid && req_ready && ce;
  endsequence
  // a strobe ending on this edge
  sequence strobe_end_s;
    $rose(rd_n) || $rose(wr_n);
  endsequence
  chk_take_busy: assert property (take_s |=> !req_ready)
    else $error("still ready after take");
  chk_done_ready: assert property (done |-> req_ready)
    else $error("not ready with done");
  chk_done_pulse: assert property (done && ce |=> !done)
    else $error("done longer than one clock");
  chk_hold_after: assert property (strobe_end_s |-> !done)
    else $error("done without hold time");
  chk_read_alone: assert property (!rd_n |-> wr_n && !ale)
    else $error("read strobe overlaps");
  chk_ale_idle: assert property (ale |-> rd_n && wr_n)
    else $error("address strobe with data strobe");
  chk_write_drive: assert property (!wr_n |-> port0_oe || port2_oe)
    else $error("write data not driven");
  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  chk_bad_addr: assert property (psel && penable && paddr > 12'h004 |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind paged_external_data_move_stretch_timing paged_external_data_move_stretch_timing_assertions chk_i (.clk, .rst, .ce,
  .psel, .penable, .paddr, .pready, .pslverr, .req_valid, .req_ready, .done, .ale, .rd_n,
  .wr_n, .port0_oe, .port2_oe);

// ===== bench/ext_mem_model.sv
`timescale 1ns/1ns
module ext_mem_model (
  input wire clk,
  input wire ale,
  input wire rd_n,
  input wire wr_n,
  input wire [7:0] port0_out,
  output logic [7:0] port0_in,
  output logic [7:0] port2_in,
  output logic [7:0] str_w,
  output logic [7:0] ale_w
);
  logic [7:0] mem [0:255];
  logic [7:0] lo = 8'h00;
  logic [7:0] sc = 8'h00;
  logic [7:0] ac = 8'h00;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // answer at once; released bus shows the inverse
  assign port0_in = rd_n ? ~mem[lo] : mem[lo];
  assign port2_in = port0_in;
  // latch address, store writes, measure pulse widths
  always @(posedge clk) begin
    if (ale) lo <= port0_out;
    if (!wr_n) mem[lo] <= port0_out;
    sc <= (!rd_n || !wr_n) ? sc + 8'h01 : 8'h00;
    ac <= ale ? ac + 8'h01 : 8'h00;
    if (rd_n && wr_n && sc != 0) str_w <= sc;
    if (!ale && ac != 0) ale_w <= ac;
  end
endmodule

// ===== bench/paged_external_data_move_stretch_timing_tb.sv
`timescale 1ns/1ns
module paged_external_data_move_stretch_timing_tb;
  logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic req_valid = 0, req_ready, req_write = 0, done, ale, rd_n, wr_n, port0_oe, port2_oe;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0] req_wdata = 8'h00, rdata, port0_out, port0_in, port2_out, port2_in, str_w, ale_w;
  int errors = 0, n_compared = 0, cyc = 0, w, len;
  logic [7:0] hi_seen, lo_seen;
  always #5 clk = ~clk;
  paged_external_data_move_stretch_timing #(.SLOW_DIV(4)) uut (.clk, .rst, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_ready, .req_write, .req_addr,
    .req_wdata, .done, .rdata, .ale, .rd_n, .wr_n, .port0_out, .port0_oe, .port0_in, .port2_out,
    .port2_oe, .port2_in);
  ext_mem_model mem (.clk, .ale, .rd_n, .wr_n, .port0_out, .port0_in, .port2_in, .str_w, .ale_w);
  task close_out;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer: setup, access until pready, release
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // one external move, waits for done
  task acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1;
    @(posedge clk);
    req_valid <= 0;
    do @(posedge clk); while (done !== 1'b1);
  endtask
  // high byte shown while the address strobe is up, low port during the read strobe
  always @(posedge clk) begin
    if (ale) hi_seen <= port2_out;
    if (!rd_n) lo_seen <= port0_out;
  end
  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000_0080);
    apb(1, 12'h000, 32'hFFFF_FFFF);
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000_01FF);
    apb(0, 12'h008, 0);
    chk(err, 1);
    apb(1, 12'h000, 32'h0000_0080);
    acc(1, 16'h1234, 8'hA5);
    acc(0, 16'h1234, 8'h00);
    chk(rdata, 8'hA5);
    // every code, non-page and page mode 2
    for (int m = 0; m < 2; m++) for (int c = 0; c < 8; c++) begin
      apb(1, 12'h000, (m ? 32'h0000_00B8 : 32'h0000_0080) | c);
      acc(0, 16'h1234, 8'h00);
      w = m ? (c ? 4 * c : 2) : (c ? 4 * c - 1 : 1);
      chk(str_w, w);
      len = (c > 3 ? 5 : 1) + (c == 0 ? 1 : c < 4 ? 2 : 9) + w + (c == 0 ? 1 : c < 4 ? 2 : 5);
      chk(hi_seen, 8'h12);
      chk(lo_seen, m ? 8'h34 : 8'h00);
      apb(0, 12'h004, 0);
      chk(rd[15:8], len);
      chk(ale_w, c > 3 ? 5 : 1);
      chk(rd[1], 1);
    end
    apb(1, 12'h000, 32'h0000_00AC);
    acc(0, 16'h5500, 8'h00);
    acc(0, 16'h5501, 8'h00);
    apb(0, 12'h004, 0);
    chk(rd[1], 0);
    chk(rd[15:8], 29);
    apb(1, 12'h000, 32'h0000_00F9);
    acc(0, 16'h1234, 8'h00);
    chk(str_w, 16);
    close_out;
  end
endmodule
